// ==== rtl/bdd_cfg.svh ====
// field positions, encodings, offsets, reset values and cycle counts of the decoder
`ifndef BDD_CFG_SVH
`define BDD_CFG_SVH

// ------------------------------------------------------------
// instruction word fields
// ------------------------------------------------------------
`define BDD_COND_HI        31
`define BDD_COND_LO        28
`define BDD_FMT_HI         27
`define BDD_FMT_LO         25
`define BDD_FMT_JUMP       3'h5
`define BDD_DP_FMT_HI      27
`define BDD_DP_FMT_LO      26
`define BDD_FMT_DP         2'h0
`define BDD_LINK_BIT       24
`define BDD_OFFSET_HI      23
`define BDD_OFFSET_LO      0
`define BDD_IMM_BIT        25
`define BDD_OPC_HI         24
`define BDD_OPC_LO         21
`define BDD_FLAG_BIT       20
`define BDD_FIRST_HI       19
`define BDD_FIRST_LO       16
`define BDD_DEST_HI        15
`define BDD_DEST_LO        12
`define BDD_OP2_HI         11
`define BDD_OP2_LO         0

// ------------------------------------------------------------
// condition codes, address arithmetic and test opcode range
// ------------------------------------------------------------
`define BDD_COND_ALWAYS    4'hE
`define BDD_COND_RESERVED  4'hF
`define BDD_PREFETCH_BYTES 32'h8
`define BDD_NEXT_BYTES     32'h4
`define BDD_TEST_LO        4'h8
`define BDD_TEST_HI        4'hB

// ------------------------------------------------------------
// jump cost: sequential and non-sequential cycles
// ------------------------------------------------------------
`define BDD_JUMP_SEQ       2
`define BDD_JUMP_NONSEQ    1

// ------------------------------------------------------------
// register port map and reset values
// ------------------------------------------------------------
`define BDD_REG_CTRL       8'h00
`define BDD_REG_STATUS     8'h04
`define BDD_REG_TARGET     8'h08
`define BDD_CTRL_RESET     1'h0
`define BDD_COUNT_RESET    16'h0000

`endif

// ==== rtl/bdd_pkg.sv ====
// types shared by the jump and data processing decoder
package bdd_pkg;

   // ---------------------------------------------------------
   // operation codes, in encoding order
   // ---------------------------------------------------------
   typedef enum logic [3:0] {
      and_op, xor_op, minus_op, reverse_minus_op,
      add_op, add_carry_op, minus_borrow_op, reverse_minus_borrow_op,
      test_and_op, test_xor_op, compare_op, compare_negated_op,
      or_op, copy_op, clear_bits_op, copy_inverted_op
   } bdd_opcode_t;

   // ---------------------------------------------------------
   // sequencer states and bus cycle kinds
   // ---------------------------------------------------------
   typedef enum logic [1:0] {st_idle, st_jump_n, st_jump_s1, st_jump_s2} bdd_state_t;
   typedef enum logic [1:0] {cyc_none, cyc_seq, cyc_nonseq} bdd_cycle_t;

   // ---------------------------------------------------------
   // carriers
   // ---------------------------------------------------------
   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } bdd_flags_t;

   typedef struct packed {
      bdd_opcode_t opcode;
      logic [3:0]  first_operand_reg;
      logic [3:0]  dest_reg;
      logic        imm_sel;
      logic        flag_update;
      logic        dest_write;
      logic [11:0] operand2;
   } bdd_dp_t;

endpackage

// ==== rtl/bdd_cond_check.sv ====
// condition field evaluation against the status word flags
`timescale 1ns/100ps
`include "bdd_cfg.svh"

module bdd_cond_check (
   // condition and flags
   input  wire logic [3:0]         cond_in,
   input  wire bdd_pkg::bdd_flags_t flags_in,
   input  wire logic               reserved_exec_in,
   // verdict
   output logic                    pass_out
);

   // ---------------------------------------------------------
   // fifteen defined conditions
   // ---------------------------------------------------------
   always_comb begin
      unique case (cond_in)
         4'h0:    pass_out = flags_in.z;
         4'h1:    pass_out = !flags_in.z;
         4'h2:    pass_out = flags_in.c;
         4'h3:    pass_out = !flags_in.c;
         4'h4:    pass_out = flags_in.n;
         4'h5:    pass_out = !flags_in.n;
         4'h6:    pass_out = flags_in.v;
         4'h7:    pass_out = !flags_in.v;
         4'h8:    pass_out = flags_in.c && !flags_in.z;
         4'h9:    pass_out = !flags_in.c || flags_in.z;
         4'hA:    pass_out = flags_in.n == flags_in.v;
         4'hB:    pass_out = flags_in.n != flags_in.v;
         4'hC:    pass_out = !flags_in.z && (flags_in.n == flags_in.v);
         4'hD:    pass_out = flags_in.z || (flags_in.n != flags_in.v);
         4'hE:    pass_out = 1'b1;
         // reserved code: software picks its fate, code must not lean on it
         4'hF:    pass_out = reserved_exec_in;
      endcase
   end

endmodule

// ==== rtl/bdd_dp_fields.sv ====
// field extraction for the data processing format
`timescale 1ns/100ps
`include "bdd_cfg.svh"

module bdd_dp_fields (
   // instruction
   input  wire logic [31:0]     instr_in,
   input  wire logic            pass_in,
   // decoded fields
   output bdd_pkg::bdd_dp_t     dp_out
);

   // ---------------------------------------------------------
   // test and compare forms never write back
   // ---------------------------------------------------------
   function automatic logic is_test(input logic [3:0] opc);
      is_test = (opc >= `BDD_TEST_LO) && (opc <= `BDD_TEST_HI);
   endfunction

   always_comb begin
      dp_out.opcode            = bdd_pkg::bdd_opcode_t'(instr_in[`BDD_OPC_HI:`BDD_OPC_LO]);
      dp_out.first_operand_reg = instr_in[`BDD_FIRST_HI:`BDD_FIRST_LO];
      dp_out.dest_reg          = instr_in[`BDD_DEST_HI:`BDD_DEST_LO];
      dp_out.imm_sel           = instr_in[`BDD_IMM_BIT];
      dp_out.flag_update       = pass_in && instr_in[`BDD_FLAG_BIT];
      dp_out.dest_write        = pass_in &&
                                 !is_test(instr_in[`BDD_OPC_HI:`BDD_OPC_LO]);
      dp_out.operand2          = instr_in[`BDD_OP2_HI:`BDD_OP2_LO];
   end

endmodule

// ==== rtl/bdd_core.sv ====
// jump and data processing decode and execute control, with its register port
`timescale 1ns/100ps
`include "bdd_cfg.svh"


module bdd_core (
   // clock and reset
   input  wire logic                clk_sys_in,
   input  wire logic                reset_in,
   // fetch side
   input  wire logic                instr_valid_in,
   input  wire logic [31:0]         instr_in,
   input  wire logic [31:0]         instr_addr_in,
   output logic                     ready_out,
   // status word
   input  wire bdd_pkg::bdd_flags_t flags_in,
   input  wire logic [4:0]          mode_in,
   // jump side
   output logic                     redirect_out,
   output logic [31:0]              target_out,
   output bdd_pkg::bdd_cycle_t      cycle_kind_out,
   // link register write
   output logic                     link_we_out,
   output logic [4:0]               link_bank_out,
   output logic [31:0]              link_data_out,
   // data processing decode
   output logic                     dp_valid_out,
   output bdd_pkg::bdd_dp_t         dp_out,
   output logic                     skipped_out,
   // register port
   input  wire logic [7:0]          reg_addr_in,
   input  wire logic [31:0]         reg_wdata_in,
   input  wire logic                reg_wr_in,
   input  wire logic                reg_rd_in,
   output logic [31:0]              reg_rdata_out
);

   // ---------------------------------------------------------
   // state
   // ---------------------------------------------------------
   typedef struct packed {
      bdd_pkg::bdd_state_t state;
      logic                redirect;
      logic [31:0]         target;
      bdd_pkg::bdd_cycle_t kind;
      logic                link_we;
      logic [4:0]          link_bank;
      logic [31:0]         link_data;
      logic                dp_valid;
      bdd_pkg::bdd_dp_t    dp;
      logic                skipped;
      logic                reserved_exec;
      logic [15:0]         jump_count;
      logic [31:0]         rdata;
   } bdd_core_state_t;

   bdd_core_state_t  s;
   bdd_core_state_t  next_s;
   logic             take;
   logic             pass;
   logic             is_jump;
   logic             is_dp;
   bdd_pkg::bdd_dp_t dp_dec;

   // ---------------------------------------------------------
   // address arithmetic
   // ---------------------------------------------------------
   function automatic logic [31:0] jump_target(input logic [31:0] addr, input logic [31:0] word);
      logic [31:0] offs;
      offs = {{6{word[`BDD_OFFSET_HI]}}, word[`BDD_OFFSET_HI:`BDD_OFFSET_LO], 2'h0};
      jump_target = addr + `BDD_PREFETCH_BYTES + offs;
   endfunction

   function automatic logic [31:0] return_addr(input logic [31:0] addr);
      logic [31:0] nxt;
      // pc+8 minus one word gives the follower
      nxt = addr + `BDD_NEXT_BYTES;
      return_addr = {nxt[31:2], 2'h0};
   endfunction

   // ---------------------------------------------------------
   // decode
   // ---------------------------------------------------------
   bdd_cond_check u_cond (
      .cond_in          (instr_in[`BDD_COND_HI:`BDD_COND_LO]),
      .flags_in         (flags_in),
      .reserved_exec_in (s.reserved_exec),
      .pass_out         (pass)
   );

   bdd_dp_fields u_dp (
      .instr_in (instr_in),
      .pass_in  (pass),
      .dp_out   (dp_dec)
   );

   assign ready_out = (s.state == bdd_pkg::st_idle);
   assign take      = instr_valid_in && ready_out;
   assign is_jump   = (instr_in[`BDD_FMT_HI:`BDD_FMT_LO] == `BDD_FMT_JUMP);
   assign is_dp     = (instr_in[`BDD_DP_FMT_HI:`BDD_DP_FMT_LO] == `BDD_FMT_DP);

   // ---------------------------------------------------------
   // next state
   // ---------------------------------------------------------
   always_comb begin
      next_s          = s;
      next_s.redirect = 1'b0;
      next_s.link_we  = 1'b0;
      next_s.dp_valid = 1'b0;
      next_s.skipped  = 1'b0;
      next_s.rdata    = 32'h0;
      unique case (s.state)
         bdd_pkg::st_idle: begin
            next_s.kind = bdd_pkg::cyc_none;
            if (take && !pass) begin
               next_s.skipped = 1'b1;
            end else if (take && is_jump) begin
               // refill fetch is the non-sequential cycle, two sequential follow
               next_s.state      = bdd_pkg::st_jump_n;
               next_s.kind       = bdd_pkg::cyc_nonseq;
               next_s.redirect   = 1'b1;
               next_s.target     = jump_target(instr_addr_in, instr_in);
               next_s.jump_count = s.jump_count + 16'h0001;
               if (instr_in[`BDD_LINK_BIT]) begin
                  next_s.link_we   = 1'b1;
                  next_s.link_bank = mode_in;
                  next_s.link_data = return_addr(instr_addr_in);
               end
            end else if (take && is_dp) begin
               next_s.dp_valid = 1'b1;
               next_s.dp       = dp_dec;
            end
         end
         bdd_pkg::st_jump_n: begin
            next_s.state = bdd_pkg::st_jump_s1;
            next_s.kind  = bdd_pkg::cyc_seq;
         end
         bdd_pkg::st_jump_s1: begin
            next_s.state = bdd_pkg::st_jump_s2;
            next_s.kind  = bdd_pkg::cyc_seq;
         end
         bdd_pkg::st_jump_s2: begin
            next_s.state = bdd_pkg::st_idle;
            next_s.kind  = bdd_pkg::cyc_none;
         end
      endcase
      if (reg_wr_in && reg_addr_in == `BDD_REG_CTRL) begin
         next_s.reserved_exec = reg_wdata_in[0];
      end
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            `BDD_REG_CTRL:   next_s.rdata = {31'h0, s.reserved_exec};
            `BDD_REG_STATUS: next_s.rdata = {15'h0, !ready_out, s.jump_count};
            `BDD_REG_TARGET: next_s.rdata = s.target;
            default:         next_s.rdata = 32'h0;
         endcase
      end
   end

   // ---------------------------------------------------------
   // registers
   // ---------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         s               <= '0;
         s.state         <= bdd_pkg::st_idle;
         s.kind          <= bdd_pkg::cyc_none;
         s.reserved_exec <= `BDD_CTRL_RESET;
         s.jump_count    <= `BDD_COUNT_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign redirect_out   = s.redirect;
   assign target_out     = s.target;
   assign cycle_kind_out = s.kind;
   assign link_we_out    = s.link_we;
   assign link_bank_out  = s.link_bank;
   assign link_data_out  = s.link_data;
   assign dp_valid_out   = s.dp_valid;
   assign dp_out         = s.dp;
   assign skipped_out    = s.skipped;
   assign reg_rdata_out  = s.rdata;

   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (reset_in);

   a_skip_no_effect: assert property (
      take && !pass |=> !redirect_out && !dp_valid_out && !link_we_out && skipped_out)
      else $error("failed condition still had an effect");

   a_jump_target_sum: assert property (
      take && pass && is_jump |=> redirect_out &&
      target_out == $past(instr_addr_in) + 32'h8 +
      {{6{$past(instr_in[23])}}, $past(instr_in[23:0]), 2'h0})
      else $error("jump target not pc plus two words plus offset");

   a_call_link_value: assert property (
      take && pass && is_jump && instr_in[24] |=>
      link_we_out && link_data_out == (($past(instr_addr_in) + 32'h4) & 32'hFFFFFFFC) &&
      link_bank_out == $past(mode_in))
      else $error("call saved a wrong return address or bank");

   a_link_low_bits: assert property (
      link_we_out |-> link_data_out[1:0] == 2'h0)
      else $error("saved return address has low bits set");

   a_plain_no_link: assert property (
      take && pass && is_jump && !instr_in[24] |=> !link_we_out [*4])
      else $error("plain jump wrote the link register");

   a_jump_cycle_cost: assert property (
      take && pass && is_jump |=> (!ready_out && cycle_kind_out == bdd_pkg::cyc_nonseq)
      ##1 (!ready_out && cycle_kind_out == bdd_pkg::cyc_seq) [*2] ##1 ready_out)
      else $error("jump did not cost one non-sequential and two sequential cycles");

   a_first_operand_field: assert property (
      take && pass && is_dp |=> dp_valid_out &&
      dp_out.first_operand_reg == $past(instr_in[19:16]) &&
      dp_out.dest_reg == $past(instr_in[15:12]))
      else $error("operand register fields taken from wrong bits");

   a_imm_select_bit: assert property (
      take && pass && is_dp |=> dp_out.imm_sel == $past(instr_in[25]))
      else $error("operand selector not bit 25");

   a_flag_update_bit: assert property (
      take && pass && is_dp |=> dp_out.flag_update == $past(instr_in[20]) &&
      dp_out.opcode == $past(instr_in[24:21]))
      else $error("flag update or opcode field wrong");

   a_test_no_write: assert property (
      dp_valid_out |-> dp_out.dest_write ==
      !(dp_out.opcode inside {bdd_pkg::test_and_op, bdd_pkg::test_xor_op,
                             bdd_pkg::compare_op, bdd_pkg::compare_negated_op}))
      else $error("destination write wrong for test or compare form");

   a_always_runs: assert property (
      take && instr_in[31:28] == 4'hE |=> !skipped_out)
      else $error("always condition was skipped");

   a_read_one_cycle: assert property (
      reg_rd_in && reg_addr_in == 8'h08 |=> reg_rdata_out == $past(s.target))
      else $error("target register read back wrong");

   // ---------------------------------------------------------
   // held outputs and gating
   // ---------------------------------------------------------
   a_skip_stays_idle: assert property (
      take && !pass |=> ready_out && $stable(dp_out) && $stable(target_out))
      else $error("failed condition moved the sequencer or outputs");

   a_answer_exclusive: assert property (
      !(skipped_out && (dp_valid_out || redirect_out)))
      else $error("skipped word also produced an answer");

   a_dp_not_jump: assert property (
      take && pass && is_dp |=> ready_out && !redirect_out && !link_we_out)
      else $error("data processing word acted as a jump");

   a_target_only_jump: assert property (
      !redirect_out |-> $stable(target_out))
      else $error("target moved without a jump");

   a_link_with_call: assert property (
      link_we_out |-> redirect_out)
      else $error("link write without its call jump");

   a_plain_link_held: assert property (
      take && pass && is_jump && !instr_in[24] |=>
      $stable(link_data_out) && $stable(link_bank_out))
      else $error("plain jump changed the saved return address");

   a_redirect_single: assert property (
      redirect_out |=> !redirect_out && !ready_out)
      else $error("redirect pulse longer than one cycle");

   a_reserved_locked: assert property (
      take && instr_in[31:28] == 4'hF && !s.reserved_exec |=> skipped_out)
      else $error("reserved condition ran while locked out");

   a_count_per_jump: assert property (
      take && pass && is_jump |=> s.jump_count == $past(s.jump_count) + 16'h0001)
      else $error("jump count did not step once");

endmodule

// ==== verif/bdd_fetch_model.sv ====
// fetch stage and link register file model facing the decoder
`timescale 1ns/100ps

module bdd_fetch_model (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        reset_in,
   // bench control
   input  wire logic        start_in,
   input  wire logic [31:0] word_in,
   input  wire logic [31:0] addr_in,
   output logic             pending_out,
   // decoder fetch side
   output logic             instr_valid_out,
   output logic [31:0]      instr_out,
   output logic [31:0]      instr_addr_out,
   input  wire logic        ready_in,
   // link register file
   input  wire logic        link_we_in,
   input  wire logic [4:0]  link_bank_in,
   input  wire logic [31:0] link_data_in,
   input  wire logic [4:0]  link_sel_in,
   output logic [31:0]      link_q_out
);
   logic [31:0] word_q;
   logic [31:0] addr_q;
   logic [31:0] link_mem [32];

   // ------------------------------------------------------------
   // offer held until taken
   // ------------------------------------------------------------
   // once taken, the lines flip so a stale word can never be mistaken for a new one
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         pending_out <= 1'b0;
         word_q      <= 32'hA5A5_5A5A;
         addr_q      <= 32'h5A5A_A5A5;
      end else if (start_in) begin
         pending_out <= 1'b1;
         word_q      <= word_in;
         addr_q      <= addr_in;
      end else if (pending_out && ready_in) begin
         pending_out <= 1'b0;
         word_q      <= ~word_q;
         addr_q      <= ~addr_q;
      end
      if (link_we_in) begin
         link_mem[link_bank_in] <= link_data_in;
      end
   end

   assign instr_valid_out = pending_out;
   assign instr_out       = word_q;
   assign instr_addr_out  = addr_q;
   assign link_q_out      = link_mem[link_sel_in];
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the jump and data processing decoder
`timescale 1ns/100ps

module testbench;
   // ------------------------------------------------------------
   // wiring
   // ------------------------------------------------------------
   logic                clk_sys_in = 1'b0;
   logic                reset_in = 1'b1;
   logic                start = 1'b0;
   logic [31:0]         word = 32'h0;
   logic [31:0]         addr = 32'h0;
   logic                pending, instr_valid, ready, redirect, link_we, dp_valid, skipped;
   logic [31:0]         instr, instr_addr, target, link_data, link_q, rdata;
   logic [4:0]          link_bank;
   logic [4:0]          mode = 5'h13;
   bdd_pkg::bdd_flags_t flags = 4'h0;
   bdd_pkg::bdd_cycle_t kind;
   bdd_pkg::bdd_dp_t    dp;
   logic [7:0]          raddr = 8'h00;
   logic [31:0]         rwdata = 32'h0;
   logic                rwr = 1'b0;
   logic                rrd = 1'b0;
   int                  errors = 0;
   int                  n_tests = 0;

   always #10 clk_sys_in = ~clk_sys_in;

   bdd_fetch_model bdd_fetch_model_inst (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in), .start_in(start), .word_in(word),
      .addr_in(addr), .pending_out(pending), .instr_valid_out(instr_valid),
      .instr_out(instr), .instr_addr_out(instr_addr), .ready_in(ready),
      .link_we_in(link_we), .link_bank_in(link_bank), .link_data_in(link_data),
      .link_sel_in(mode), .link_q_out(link_q));

   bdd_core bdd_core_inst (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in), .instr_valid_in(instr_valid),
      .instr_in(instr), .instr_addr_in(instr_addr), .ready_out(ready), .flags_in(flags),
      .mode_in(mode), .redirect_out(redirect), .target_out(target), .cycle_kind_out(kind),
      .link_we_out(link_we), .link_bank_out(link_bank), .link_data_out(link_data),
      .dp_valid_out(dp_valid), .dp_out(dp), .skipped_out(skipped), .reg_addr_in(raddr),
      .reg_wdata_in(rwdata), .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rdata));

   // ------------------------------------------------------------
   // access and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      rwr    <= 1'b1;
      raddr  <= a;
      rwdata <= d;
      @(posedge clk_sys_in);
      rwr    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input string n);
      @(posedge clk_sys_in);
      rrd   <= 1'b1;
      raddr <= a;
      @(posedge clk_sys_in);
      rrd   <= 1'b0;
      #1;
      chk(n, e, rdata);
   endtask

   // returns one ns after the edge that took the word, where the answer stands
   task automatic issue(input logic [31:0] w, input logic [31:0] a,
                        input bdd_pkg::bdd_flags_t fl);
      int k;
      @(posedge clk_sys_in);
      start <= 1'b1;
      word  <= w;
      addr  <= a;
      flags <= fl;
      @(posedge clk_sys_in);
      start <= 1'b0;
      k = 0;
      do begin
         @(posedge clk_sys_in);
         #1;
         k++;
      end while (pending !== 1'b0 && k < 20);
      chk("word taken", 32'h0, {31'h0, pending});
   endtask

   task automatic jump(input logic [31:0] w, input logic [31:0] a, input logic [31:0] t,
                       input logic call);
      issue(w, a, 4'h0);
      chk("redirect", 32'h1, {31'h0, redirect});
      chk("target", t, target);
      chk("link write", {31'h0, call}, {31'h0, link_we});
      chk("cycle n", 32'h2, {30'h0, kind});
      chk("ready low", 32'h0, {31'h0, ready});
      repeat (2) begin
         @(posedge clk_sys_in);
         #1;
         chk("cycle s", 32'h1, {30'h0, kind});
         chk("busy", 32'h0, {30'h0, ready, redirect});
      end
      @(posedge clk_sys_in);
      #1;
      chk("cycle end", 32'h1, {29'h0, kind, ready});
   endtask

   function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f, input logic r);
      logic n, z, cy, v;
      {n, z, cy, v} = f;
      case (c)
         4'h0: return z;
         4'h1: return !z;
         4'h2: return cy;
         4'h3: return !cy;
         4'h4: return n;
         4'h5: return !n;
         4'h6: return v;
         4'h7: return !v;
         4'h8: return cy && !z;
         4'h9: return !cy || z;
         4'hA: return n == v;
         4'hB: return n != v;
         4'hC: return !z && (n == v);
         4'hD: return z || (n != v);
         4'hE: return 1'b1;
         default: return r;
      endcase
   endfunction

   task automatic dp_run(input logic [3:0] c, input logic [3:0] f, input logic [3:0] op,
                         input logic [11:0] o2, input logic e);
      logic dw;
      dw = !(op >= 4'h8 && op <= 4'hB);
      issue({c, 2'h0, o2[0], op, o2[1], o2[7:4], ~o2[7:4], o2}, 32'h100, f);
      chk("dp valid", {31'h0, e}, {31'h0, dp_valid});
      chk("skipped", {31'h0, !e}, {31'h0, skipped});
      chk("dp ready", 32'h1, {31'h0, ready});
      if (e) begin
         chk("dp fields", {5'h0, op, o2[7:4], ~o2[7:4], o2[0], o2[1], dw, o2},
             {5'h0, dp});
      end
   endtask

   task automatic final_report;
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      int c, f;
      repeat (3) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      #1;
      chk("reset state", 32'h1, {29'h0, kind, ready});
      reg_rd(8'h04, 32'h0, "status");
      reg_rd(8'h08, 32'h0, "target reg");
      reg_wr(8'h0C, 32'hFFFF_FFFF);
      reg_rd(8'h00, 32'h0, "ctrl");
      reg_rd(8'h0C, 32'h0, "unmapped");
      jump({4'hE, 3'h5, 1'b1, 24'hFFFFFE}, 32'h1002, 32'h1002, 1'b1);
      chk("link data", 32'h1004, link_data);
      chk("link bank", 32'h13, {27'h0, link_bank});
      jump({4'hE, 3'h5, 1'b0, 24'h7FFFFF}, 32'h2000, 32'h0200_2004, 1'b0);
      chk("link kept", 32'h1004, link_q);
      issue({4'h0, 3'h5, 1'b1, 24'h0}, 32'h3000, 4'h0);
      chk("jump skipped", 32'h9, {29'h0, skipped, redirect, link_we, ready});
      reg_rd(8'h04, 32'h2, "jump count");
      reg_rd(8'h08, 32'h0200_2004, "target reg");
      // every condition against every flag pattern, reserved code locked out
      for (c = 0; c < 16; c++) begin
         for (f = 0; f < 16; f++) begin
            dp_run(c[3:0], f[3:0], 4'hD, 12'h5A3, cond_ok(c[3:0], f[3:0], 1'b0));
         end
      end
      reg_wr(8'h00, 32'h1);
      reg_rd(8'h00, 32'h1, "ctrl");
      dp_run(4'hF, 4'h0, 4'h0, 12'h3C1, 1'b1);
      // every operation code, operand selector and flag bit
      for (c = 0; c < 16; c++) begin
         dp_run(4'hE, 4'h0, c[3:0], 12'h940 ^ {4'h0, c[3:0], 2'h0, c[1:0]}, 1'b1);
      end
      final_report;
   end

   initial begin
      #400000;
      errors++;
      final_report;
   end
endmodule
